// File: src/pes_pkg.sv
/*
  types shared by the serializer: switch bundle, supply sense bundle and
  the link side frame state.
  assumes nothing beyond a systemverilog compiler.
*/
package pes_pkg;

  // static configuration switches, read as pins
  typedef struct packed {
    logic       two_encoders;   // off: one encoder, on: two
    logic       gray_code;      // encoder delivers gray code
    logic       negative_logic; // low level reads as one
    logic [1:0] chain_slot;     // first select code owned here
  } pes_switch_s;

  // supply monitor and encoder fault pins
  typedef struct packed {
    logic pos_return_low;   // + return dropped past trip level
    logic neg_return_high;  // - return rose past trip level
    logic encoder_fault;    // fault line from the encoder
  } pes_supply_s;

  // frame state on the link clock
  typedef enum logic [0:0] {
    PES_IDLE,
    PES_SHIFT
  } pes_link_e;

endpackage

// File: src/pes_regs.svh
/*
  fixed figures of the parallel encoder serializer: word limits, chain
  limits, clock rates, supply trip level and select steps.
  assumes it is included by bare name from the serializer module only.
*/
`ifndef PES_REGS_SVH
`define PES_REGS_SVH

// widest position word an encoder may present
`define PES_WORD_BITS_MAX    24
// default position word width
`define PES_WORD_BITS_DEF    24
// encoders one adaptor can serve
`define PES_ENC_PER_ADAPTOR  2
// adaptors that may share one counter channel
`define PES_CHAIN_MAX        4
// select code distance from encoder a to encoder b
`define PES_SEL_B_STEP       2'h1
// system clock rate in hz
`define PES_SYS_HZ           250000000
// frame read clock limits in hz
`define PES_FRAME_HZ_MIN     150000
`define PES_FRAME_HZ_MAX     1000000
// fastest change of the least significant bit in hz
`define PES_LSB_HZ_MAX       75000
// supply return trip level, percent of the supply
`define PES_SUPPLY_TRIP_PCT  15
// settle wait after a select change, system cycles
`define PES_SETTLE_DEF       16
// value of the inhibit pin while an encoder is parked
`define PES_INHIBIT_ON       1'b1

`endif

// File: src/pes_serializer.sv
/*
  parallel absolute encoder to serial frame adaptor. samples the word of
  the selected encoder on the system clock, buffers it, hands it across
  to the read clock domain and shifts it out msb first per frame.
  assumes the read clock and frame strobe come from the counter channel,
  and that all pins on the encoder side are asynchronous levels.
*/
// Contract
// - capture selected encoder word, send it serially
// - one adaptor serves up to two encoders
// - up to four adaptors share one channel
// - frame read clock stays 150 khz to 1 mhz
// - words with lsb up to 75 khz captured
// - polarity switch inverts input level meaning
// - encoder count and type come from switches
// - flag supply return drift beyond fifteen percent
// - lone adaptor: 00 reads a, 01 reads b
// - separate inhibit to each encoder, unselected parked
// - count switch off one encoder, on two
`timescale 1ns/1ns
`include "pes_regs.svh"
module pes_serializer #(
  parameter int WIDTH         = `PES_WORD_BITS_DEF,
  parameter int BUF_DEPTH     = 2,
  parameter int SETTLE_CYCLES = `PES_SETTLE_DEF,
  parameter int SYS_HZ        = `PES_SYS_HZ
) (
  // system clock, reset and enable
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  input  wire logic                clk_en_i,
  // encoder side pins, asynchronous
  input  wire logic [WIDTH-1:0]    encoder_position_inputs_i,
  input  wire logic                encoder_select_low_i,
  input  wire logic                encoder_select_high_i,
  input  wire pes_pkg::pes_switch_s switches_i,
  input  wire pes_pkg::pes_supply_s supply_return_sense_i,
  output logic                     encoder_a_output_inhibit_o,
  output logic                     encoder_b_output_inhibit_o,
  // status
  output logic                     read_selected_o,
  output logic                     supply_fault_o,
  output logic                     encoder_fault_o,
  // link to the counter channel, on its read clock
  input  wire logic                clk_read_i,
  input  wire logic                frame_i,
  output logic                     serial_data_o,
  output logic                     serial_oe_o
);

  localparam int PTR   = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(WIDTH + 1);
  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
  localparam int IN_W  = WIDTH + 10;
  // sys cycles per half lsb period; a sample must land inside it
  localparam int LSB_HALF_CYC = SYS_HZ / (2 * `PES_LSB_HZ_MAX);

  // refuse settings the logic cannot serve
  if (WIDTH < 1 || WIDTH > `PES_WORD_BITS_MAX) begin : g_bad_width
    $error("word width out of range");
  end
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_dep
    $error("buffer depth must be a power of two, two or more");
  end
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= LSB_HALF_CYC) begin : g_bad_set
    $error("settle wait too long for the fastest lsb");
  end
  if (SYS_HZ < 8 * `PES_FRAME_HZ_MAX) begin : g_bad_hz
    $error("system clock too slow for the frame clock");
  end

  // synchronized pin bundle
  logic [IN_W-1:0]      pins_s;
  logic [WIDTH-1:0]     pos_s;
  logic                 sel_low_s;
  logic                 sel_high_s;
  pes_pkg::pes_switch_s sw_s;
  pes_pkg::pes_supply_s sup_s;

  // every encoder side pin passes two flops before any logic reads it
  pes_sync #(
    .W(IN_W)
  ) u_pin_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (resetn_i),
    .d_i     ({encoder_position_inputs_i, encoder_select_low_i,
               encoder_select_high_i, switches_i, supply_return_sense_i}),
    .q_o     (pins_s)
  );

  assign {pos_s, sel_low_s, sel_high_s, sw_s, sup_s} = pins_s;

  // select decode; a lone adaptor has slot 00
  wire [1:0] sel_code = {sel_high_s, sel_low_s};
  wire [1:0] slot_b   = sw_s.chain_slot + `PES_SEL_B_STEP;
  wire       pick_a   = (sel_code == sw_s.chain_slot);
  wire       pick_b   = sw_s.two_encoders && (sel_code == slot_b);
  wire       picked   = pick_a | pick_b;

  // polarity and code conversion
  wire [WIDTH-1:0] level_word = pos_s ^ {WIDTH{sw_s.negative_logic}};
  wire [WIDTH-1:0] bin_word;
  assign bin_word[WIDTH-1] = level_word[WIDTH-1];
  for (genvar i = 0; i < WIDTH - 1; i++) begin : g_gray
    assign bin_word[i] = bin_word[i+1] ^ level_word[i];
  end
  // gray decoded so the counter always receives pure binary
  wire [WIDTH-1:0] pos_word = sw_s.gray_code ? bin_word : level_word;

  // settle wait and select tracking
  logic [1:0]       sel_prev_q;
  logic [SET_W-1:0] settle_q;
  logic [SET_W-1:0] settle_d;
  wire              sel_moved = (sel_code != sel_prev_q);
  wire              settled   = (settle_q == '0) && !sel_moved;
  assign settle_d = sel_moved ? SET_W'(SETTLE_CYCLES)
                  : (settle_q != '0) ? settle_q - SET_W'(1) : settle_q;

  // two entry buffer between sampler and crossing
  logic [WIDTH-1:0] buf_q [BUF_DEPTH];
  logic [PTR-1:0]   wr_ptr_q;
  logic [PTR-1:0]   rd_ptr_q;
  logic [PTR:0]     fill_q;
  wire              push_valid = picked && settled;
  wire              push_ready = (fill_q != (PTR+1)'(BUF_DEPTH));
  wire              push       = push_valid;
  wire              pop_valid  = (fill_q != '0);
  // crossing side of the handshake
  logic             req_q;       // toggles once per word sent
  logic [WIDTH-1:0] xfer_q;      // stable while a toggle is pending
  logic             ack_s;       // link acknowledge, synchronized
  wire              pop_ready  = (req_q == ack_s);
  wire              pop        = pop_valid && pop_ready;
  // a full buffer that nobody reads sheds its oldest sample, so a stopped
  // read clock cannot leave stale positions queued for the next frame
  wire              drop       = push_valid && !push_ready && !pop;
  wire [PTR:0]      fill_d     = fill_q + (PTR+1)'(push)
                               - (PTR+1)'(pop | drop);

  // sampler: a busy crossing stalls the pop; a full buffer sheds its head
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_prev_q <= 2'h0;
      settle_q   <= SET_W'(SETTLE_CYCLES);
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      fill_q     <= '0;
    end else if (clk_en_i) begin
      sel_prev_q <= sel_code;
      settle_q   <= settle_d;
      fill_q     <= fill_d;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PTR'(1);
      end
      if (pop | drop) begin
        rd_ptr_q <= rd_ptr_q + PTR'(1);
      end
    end
  end

  // buffer storage, indexed by the write pointer
  always_ff @(posedge clk_sys_i) begin
    if (clk_en_i && push) begin
      buf_q[wr_ptr_q] <= pos_word;
    end
  end

  // hand the head word to the crossing register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_q  <= 1'b0;
      xfer_q <= '0;
    end else if (clk_en_i && pop) begin
      xfer_q <= buf_q[rd_ptr_q];
      req_q  <= ~req_q;
    end
  end

  // pin outputs and status flags
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      encoder_a_output_inhibit_o <= `PES_INHIBIT_ON;
      encoder_b_output_inhibit_o <= `PES_INHIBIT_ON;
      read_selected_o            <= 1'b0;
      supply_fault_o             <= 1'b0;
      encoder_fault_o            <= 1'b0;
    end else if (clk_en_i) begin
      // only the chosen encoder may drive the shared inputs
      encoder_a_output_inhibit_o <= !pick_a;
      encoder_b_output_inhibit_o <= !pick_b;
      read_selected_o            <= picked;
      // comparators trip at the fifteen percent level
      supply_fault_o  <= sup_s.pos_return_low | sup_s.neg_return_high;
      encoder_fault_o <= sup_s.encoder_fault;
    end
  end

  // link reset: asserts at once, releases on the read clock
  logic lrst_meta_q;
  logic lrst_n_q;
  always_ff @(posedge clk_read_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_meta_q <= 1'b0;
      lrst_n_q    <= 1'b0;
    end else begin
      lrst_meta_q <= 1'b1;
      lrst_n_q    <= lrst_meta_q;
    end
  end

  // request, enable and selection into the link domain
  logic [2:0] to_link_s;
  wire        req_l = to_link_s[2];
  wire        en_l  = to_link_s[1];
  wire        sel_l = to_link_s[0];
  pes_sync #(
    .W(3)
  ) u_to_link (
    .clk_i   (clk_read_i),
    .rst_n_i (lrst_n_q),
    .d_i     ({req_q, clk_en_i, read_selected_o}),
    .q_o     (to_link_s)
  );

  // acknowledge back into the system domain
  logic ack_q;
  pes_sync #(
    .W(1)
  ) u_to_sys (
    .clk_i   (clk_sys_i),
    .rst_n_i (resetn_i),
    .d_i     (ack_q),
    .q_o     (ack_s)
  );

  // link side word and frame shifter
  logic [WIDTH-1:0]  word_l_q;  // newest word handed across
  logic [WIDTH-1:0]  shift_q;   // frame copy, untouched by new words
  logic [CNT_W-1:0]  bit_cnt_q; // bits already put on the line
  pes_pkg::pes_link_e state_q;
  wire               take_word = (req_l != ack_q);
  wire               last_bit  = (bit_cnt_q == CNT_W'(WIDTH));

  // a stopped read clock only delays the acknowledge; the next pop waits
  always_ff @(posedge clk_read_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      ack_q    <= 1'b0;
      word_l_q <= '0;
    end else if (en_l && take_word) begin
      word_l_q <= xfer_q;
      ack_q    <= req_l;
    end
  end

  // one bit per read clock edge, msb first
  always_ff @(posedge clk_read_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      state_q       <= pes_pkg::PES_IDLE;
      shift_q       <= '0;
      bit_cnt_q     <= '0;
      serial_data_o <= 1'b0;
      serial_oe_o   <= 1'b0;
    end else if (en_l) begin
      case (state_q)
        pes_pkg::PES_IDLE: begin
          if (frame_i) begin
            // latch the whole word so it cannot tear mid frame
            shift_q       <= word_l_q << 1;
            serial_data_o <= word_l_q[WIDTH-1];
            serial_oe_o   <= sel_l;
            bit_cnt_q     <= CNT_W'(1);
            state_q       <= pes_pkg::PES_SHIFT;
          end
        end
        pes_pkg::PES_SHIFT: begin
          if (!frame_i || last_bit) begin
            // frame ended or aborted: release the shared line
            serial_oe_o <= 1'b0;
            bit_cnt_q   <= '0;
            state_q     <= pes_pkg::PES_IDLE;
          end else begin
            serial_data_o <= shift_q[WIDTH-1];
            shift_q       <= shift_q << 1;
            bit_cnt_q     <= bit_cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= pes_pkg::PES_IDLE;
        end
      endcase
    end
  end

endmodule

// File: src/pes_sync.sv
/*
  two flop level synchronizer, one bit or a bundle of unrelated bits.
  assumes every bit is a slow level; multi bit words need a handshake.
*/
`timescale 1ns/1ns
module pes_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // asynchronous levels in, synchronized levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;  // first stage, read only by the second
  logic [W-1:0] sync_q;  // second stage, safe to use

  // synchronizers run free so a frozen enable is still seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// File: testbench/pes_counter_channel.sv
/*
  counter channel model: clocks serial frames out of the adaptor.
  assumes the caller runs one frame at a time; clock idles between them.
*/
`timescale 1ns/1ns
module pes_counter_channel #(
  parameter int WIDTH = 24
) (
  // link outputs
  output logic clk_read_o,
  output logic frame_o,
  // shared serial line
  input  wire logic serial_data_i,
  input  wire logic serial_oe_i
);
  logic run; // read clock allowed to run
  // 32 ns clock, offset so its edges never meet the system clock's
  initial begin
    clk_read_o = 1'b0;
    frame_o    = 1'b0;
    run        = 1'b0;
    #5;
    forever begin
      #16;
      if (run || clk_read_o) clk_read_o = ~clk_read_o;
    end
  end
  // lead-in edges let the word cross; nbits below WIDTH aborts the frame
  task automatic read_frame(input int nbits, output logic [WIDTH-1:0] word,
                            output int oe_cnt);
    oe_cnt = 0;
    word   = '0;
    run    = 1'b1;
    repeat (8) @(posedge clk_read_o);
    frame_o <= 1'b1;
    repeat (nbits) begin
      @(posedge clk_read_o);
      @(negedge clk_read_o);
      word = {word[WIDTH-2:0], serial_data_i};
      if (serial_oe_i !== 1'b0) oe_cnt++;
    end
    if (nbits == WIDTH) @(posedge clk_read_o);
    frame_o <= 1'b0;
    repeat (2) @(posedge clk_read_o);
    @(negedge clk_read_o);
    if (serial_oe_i !== 1'b0) oe_cnt++;
    run = 1'b0;
  endtask
endmodule

// File: testbench/pes_serializer_assertions.sv
/*
  concurrent checks on the serializer's ports: select decoding, inhibits,
  supply flags and link framing. assumes it is bound to pes_serializer.
*/
`timescale 1ns/1ns
module pes_serializer_assertions #(
  parameter int WIDTH = 24
) (
  // clocks, reset, enable
  input wire logic                 clk_sys_i,
  input wire logic                 resetn_i,
  input wire logic                 clk_en_i,
  input wire logic                 clk_read_i,
  // pins and status
  input wire logic                 encoder_select_low_i,
  input wire logic                 encoder_select_high_i,
  input wire pes_pkg::pes_switch_s switches_i,
  input wire pes_pkg::pes_supply_s supply_return_sense_i,
  input wire logic                 encoder_a_output_inhibit_o,
  input wire logic                 encoder_b_output_inhibit_o,
  input wire logic                 read_selected_o,
  input wire logic                 supply_fault_o,
  input wire logic                 encoder_fault_o,
  // link
  input wire logic                 frame_i,
  input wire logic                 serial_oe_o
);
  wire logic [1:0] sel_w;   // select code as driven
  wire logic [1:0] b_code_w; // code of encoder b
  wire logic       own_b_w;  // code owned by encoder b
  logic      [7:0] oe_run_q; // read edges with oe high in a row
  assign sel_w    = {encoder_select_high_i, encoder_select_low_i};
  assign b_code_w = switches_i.chain_slot + 2'h1;
  assign own_b_w  = switches_i.two_encoders && sel_w == b_code_w;
  // counts the frame length as the reader sees it
  always_ff @(posedge clk_read_i or negedge resetn_i) begin
    if (!resetn_i) oe_run_q <= 8'h00;
    else if (serial_oe_o) oe_run_q <= oe_run_q + 8'h01;
    else oe_run_q <= 8'h00;
  end
  // five stable cycles cover two sync flops plus the output flop
  property p_sel_a;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (sel_w == switches_i.chain_slot && clk_en_i)[*5] |-> read_selected_o
      && !encoder_a_output_inhibit_o && encoder_b_output_inhibit_o;
  endproperty
  a_sel_a: assert property (p_sel_a)
    else $error("encoder a not selected");
  property p_sel_b;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (own_b_w && switches_i.chain_slot != 2'h3 && clk_en_i)[*5]
      |-> read_selected_o && !encoder_b_output_inhibit_o
      && encoder_a_output_inhibit_o;
  endproperty
  a_sel_b: assert property (p_sel_b)
    else $error("encoder b not selected");
  property p_no_read;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (sel_w != switches_i.chain_slot && !own_b_w && clk_en_i)[*5]
      |-> !read_selected_o && encoder_a_output_inhibit_o
      && encoder_b_output_inhibit_o;
  endproperty
  a_no_read: assert property (p_no_read)
    else $error("foreign code read");
  property p_excl;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    encoder_a_output_inhibit_o || encoder_b_output_inhibit_o;
  endproperty
  a_excl: assert property (p_excl)
    else $error("both encoders released");
  property p_sup_set;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ((supply_return_sense_i.pos_return_low
      || supply_return_sense_i.neg_return_high) && clk_en_i)[*5]
      |-> supply_fault_o;
  endproperty
  a_sup_set: assert property (p_sup_set)
    else $error("supply fault missed");
  property p_sup_clr;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!supply_return_sense_i.pos_return_low
      && !supply_return_sense_i.neg_return_high && clk_en_i)[*5]
      |-> !supply_fault_o;
  endproperty
  a_sup_clr: assert property (p_sup_clr)
    else $error("supply fault without cause");
  property p_fault;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (supply_return_sense_i.encoder_fault && clk_en_i)[*5]
      |-> encoder_fault_o;
  endproperty
  a_fault: assert property (p_fault)
    else $error("encoder fault missed");
  property p_oe_len;
    @(posedge clk_read_i) disable iff (!resetn_i) oe_run_q <= WIDTH;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("frame longer than word");
  property p_abort;
    @(posedge clk_read_i) disable iff (!resetn_i)
    !frame_i |=> !serial_oe_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("line held after frame end");
  property p_oe_start;
    @(posedge clk_read_i) disable iff (!resetn_i)
    $rose(serial_oe_o) |-> $past(frame_i);
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("line driven without frame");
endmodule
bind pes_serializer pes_serializer_assertions #(.WIDTH(WIDTH))
  i_pes_serializer_assertions (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .clk_read_i(clk_read_i), .encoder_select_low_i(encoder_select_low_i),
  .encoder_select_high_i(encoder_select_high_i), .switches_i(switches_i),
  .supply_return_sense_i(supply_return_sense_i),
  .encoder_a_output_inhibit_o(encoder_a_output_inhibit_o),
  .encoder_b_output_inhibit_o(encoder_b_output_inhibit_o),
  .read_selected_o(read_selected_o), .supply_fault_o(supply_fault_o),
  .encoder_fault_o(encoder_fault_o), .frame_i(frame_i),
  .serial_oe_o(serial_oe_o));

// File: testbench/tb_pes_serializer.sv
/*
  self-checking bench: random and corner selections, polarity and code
  settings, supply faults, aborted and disturbed frames.
  assumes the design package and the counter channel model are compiled.
*/
`timescale 1ns/1ns
module tb_pes_serializer;
  logic                 clk_sys, resetn, clk_en, sel_lo, sel_hi;
  logic          [23:0] enc;
  pes_pkg::pes_switch_s sw;
  pes_pkg::pes_supply_s sup;
  pes_pkg::pes_switch_s s_rand; // switch setting drawn for the next case
  wire logic            inh_a, inh_b, rsel, sfault, efault;
  wire logic            clk_rd, frame, sdata, soe;
  int                   fails, tests_run, cycles;
  logic          [23:0] w;
  int                   n;
  // corners {two, gray, neg, slot, select}
  logic           [6:0] corner [6] = '{7'b1000000, 7'b1000001, 7'b1000010,
                                       7'b1011011, 7'b0000001, 7'b1101011};
  pes_serializer #(.WIDTH(24), .SETTLE_CYCLES(4)) i_pes_serializer (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .clk_en_i(clk_en),
    .encoder_position_inputs_i(enc), .encoder_select_low_i(sel_lo),
    .encoder_select_high_i(sel_hi), .switches_i(sw),
    .supply_return_sense_i(sup), .encoder_a_output_inhibit_o(inh_a),
    .encoder_b_output_inhibit_o(inh_b), .read_selected_o(rsel),
    .supply_fault_o(sfault), .encoder_fault_o(efault),
    .clk_read_i(clk_rd), .frame_i(frame), .serial_data_o(sdata),
    .serial_oe_o(soe));
  pes_counter_channel #(.WIDTH(24)) i_pes_counter_channel (
    .clk_read_o(clk_rd), .frame_o(frame), .serial_data_i(sdata),
    .serial_oe_i(soe));
  always #2 clk_sys = ~clk_sys;
  // hang guard: far above the ~7800 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // level mapping first, then gray to binary, msb down
  function automatic logic [23:0] exp_word(input logic [23:0] raw,
                                           input pes_pkg::pes_switch_s s);
    logic [23:0] v;
    v = s.negative_logic ? ~raw : raw;
    if (s.gray_code) for (int i = 22; i >= 0; i--) v[i] = v[i + 1] ^ v[i];
    return v;
  endfunction
  // {encoder b owns code, encoder a owns code}
  function automatic logic [1:0] exp_hit(input pes_pkg::pes_switch_s s,
                                         input logic [1:0] c);
    return {s.two_encoders && c == s.chain_slot + 2'h1, c == s.chain_slot};
  endfunction
  task automatic run_case(input pes_pkg::pes_switch_s s,
                          input logic [1:0] c, input logic [23:0] raw,
                          input pes_pkg::pes_supply_s p);
    logic [1:0] hit;
    hit = exp_hit(s, c);
    @(posedge clk_sys);
    sw <= s;
    {sel_hi, sel_lo} <= c;
    enc <= raw;
    sup <= p;
    repeat (40) @(posedge clk_sys);
    #1;
    check({inh_b, inh_a, rsel}, {~hit, |hit});
    check({sfault, efault}, {p[2] | p[1], p[0]});
    i_pes_counter_channel.read_frame(24, w, n);
    check(n, (|hit) ? 24 : 0);
    if (|hit) check(w, exp_word(raw, s));
  endtask
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    {sel_hi, sel_lo} = 2'h0;
    enc = 24'h000000;
    sw = '0;
    sup = '0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(91));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      s_rand = (i < 6) ? corner[i][6:2] : 5'($urandom);
      if (s_rand.chain_slot == 2'h3) s_rand.two_encoders = 1'b0;
      run_case(s_rand, (i < 6) ? corner[i][1:0] : 2'($urandom),
               24'($urandom), 3'($urandom));
    end
    run_case(5'b10000, 2'h0, 24'hA5C396, 3'h0);
    // frozen enable holds the selection
    @(posedge clk_sys);
    clk_en <= 1'b0;
    sel_lo <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check({inh_b, inh_a}, 2'b10);
    clk_en <= 1'b1;
    sel_lo <= 1'b0;
    repeat (20) @(posedge clk_sys);
    i_pes_counter_channel.read_frame(5, w, n);
    check({w[4:0], n[7:0]}, {5'h14, 8'h05});
    // word changes mid-frame; the latched one must come out
    fork
      i_pes_counter_channel.read_frame(24, w, n);
      begin
        repeat (100) @(posedge clk_sys);
        enc <= 24'h5A3C69;
      end
    join
    check(w, 24'hA5C396);
    results();
  end
endmodule
